// *** spi_reset_power_and_pins_test.sv ***
// Self-checking bench: port as slave facing the master peer, then as master for the mode fault
`timescale 1ns/1ps
module spi_reset_power_and_pins_test;
  logic ref_clk, rst_b, cpu_rd, cpu_wr, wait_mode, stop_mode, irq, pins_owned;
  logic break_state, break_clear_enable;
  logic [7:0] cpu_addr, cpu_wdata, cpu_rdata, rd;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [3:0] awaddr, araddr;
  logic [31:0] wdata, rdata, prd;
  logic [1:0] bresp, rresp, presp;
  int n_mismatch, n_checks;
  srp_link_if lnk ();
  srp_port srp_port_i (.ref_clk(ref_clk), .rst_b(rst_b), .cpu_addr(cpu_addr),
    .cpu_rd(cpu_rd), .cpu_wr(cpu_wr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .wait_mode(wait_mode), .stop_mode(stop_mode), .break_state(break_state),
    .break_clear_enable(break_clear_enable), .irq(irq), .pins_owned(pins_owned),
    .link(lnk.dev));
  srp_peer #(.HALF_CYC(8'h08)) srp_peer_i (.ref_clk(ref_clk), .rst_b(rst_b),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .link(lnk.peer));
  srp_link_sva srp_link_sva_i (.ref_clk(ref_clk), .rst_b(rst_b),
    .dev_sclk_oe(lnk.dev_sclk_oe), .dev_mosi_oe(lnk.dev_mosi_oe),
    .dev_miso_o(lnk.dev_miso_o), .dev_miso_oe(lnk.dev_miso_oe),
    .sclk(lnk.sclk), .ss_n(lnk.ss_n));
  // 100 ns core clock
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // CPU strobes last one cycle; read data lands a cycle later
  task automatic cwr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    cpu_addr <= a;
    cpu_wdata <= d;
    cpu_wr <= 1'b1;
    @(posedge ref_clk);
    cpu_wr <= 1'b0;
  endtask
  task automatic crd(input logic [7:0] a);
    @(posedge ref_clk);
    cpu_addr <= a;
    cpu_rd <= 1'b1;
    @(posedge ref_clk);
    cpu_rd <= 1'b0;
    @(posedge ref_clk);
    rd = cpu_rdata;
  endtask
  // AXI write: each channel released only at its own handshake
  task automatic awr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge ref_clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid)
      begin
        bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic ard(input logic [3:0] a);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge ref_clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid)
      begin
        prd = rdata;
        presp = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask
  // Start one peer byte and poll until busy has come and gone
  task automatic pxfer(input logic [7:0] b);
    bit seen;
    seen = 1'b0;
    awr(srp_pkg::P_TX, {24'h000000, b});
    for (int i = 0; i < 200; i++)
    begin
      ard(srp_pkg::P_STAT);
      if (prd[srp_pkg::P_BUSY])
        seen = 1'b1;
      else if (seen)
        break;
    end
  endtask
  task automatic t_reset;
    crd(srp_pkg::CTRL_ADDR);
    chk("ctrl", 8'h28, rd);
    crd(srp_pkg::STAT_ADDR);
    chk("status", 8'h08, rd);
    chk("owned", 1'b0, pins_owned);
    ard(4'hC);
    chk("unmapped resp", srp_pkg::RESP_SLVERR, presp);
    awr(4'hC, 32'h0);
    chk("unmapped wresp", srp_pkg::RESP_SLVERR, bresp);
  endtask
  // Phase 0 slave byte; error enable, fault detect, baud 3 set too
  task automatic t_xfer0;
    cwr(srp_pkg::CTRL_ADDR, 8'h02);
    cwr(srp_pkg::STAT_ADDR, 8'h47);
    cwr(srp_pkg::DATA_ADDR, 8'hA5);
    chk("owned", 1'b1, pins_owned);
    awr(srp_pkg::P_CTRL, 32'h0);
    pxfer(8'h3C);
    ard(srp_pkg::P_STAT);
    chk("peer rx", 8'hA5, prd[7:0]);
    chk("miso oe", 1'b0, lnk.dev_miso_oe);
    crd(srp_pkg::STAT_ADDR);
    chk("status", 8'hCF, rd);
    crd(srp_pkg::DATA_ADDR);
    chk("rx byte", 8'h3C, rd);
  endtask
  // Overrun, then disable: flags and control bits must survive
  task automatic t_overrun;
    pxfer(8'h01);
    pxfer(8'h02);
    crd(srp_pkg::STAT_ADDR);
    chk("status", 8'hEF, rd);
    chk("irq", 1'b1, irq);
    cwr(srp_pkg::CTRL_ADDR, 8'h80);
    cwr(srp_pkg::DATA_ADDR, 8'h99);
    crd(srp_pkg::STAT_ADDR);
    chk("status", 8'hEF, rd);
    crd(srp_pkg::CTRL_ADDR);
    chk("ctrl", 8'h80, rd);
    chk("owned", 1'b0, pins_owned);
    chk("oe", 3'h0, {lnk.dev_sclk_oe, lnk.dev_mosi_oe, lnk.dev_miso_oe});
  endtask
  task automatic t_wait;
    wait_mode <= 1'b1;
    cwr(srp_pkg::CTRL_ADDR, 8'h02);
    crd(srp_pkg::DATA_ADDR);
    chk("irq", 1'b1, irq);
    wait_mode <= 1'b0;
    crd(srp_pkg::CTRL_ADDR);
    chk("ctrl", 8'h80, rd);
    crd(srp_pkg::STAT_ADDR);
    chk("status", 8'hEF, rd);
  endtask
  // First clearing step before break, second only after it
  task automatic t_break;
    cwr(srp_pkg::CTRL_ADDR, 8'h02);
    crd(srp_pkg::STAT_ADDR);
    break_state <= 1'b1;
    crd(srp_pkg::DATA_ADDR);
    cwr(srp_pkg::DATA_ADDR, 8'h55);
    crd(srp_pkg::STAT_ADDR);
    chk("status", 8'hEF, rd);
    break_state <= 1'b0;
    crd(srp_pkg::DATA_ADDR);
    chk("rx byte", 8'h01, rd);
    crd(srp_pkg::STAT_ADDR);
    chk("status", 8'h4F, rd);
  endtask
  // Phase 1, select held low over two bytes
  task automatic t_phase1;
    cwr(srp_pkg::CTRL_ADDR, 8'h0A);
    cwr(srp_pkg::DATA_ADDR, 8'h81);
    awr(srp_pkg::P_CTRL, 32'h5);
    pxfer(8'h11);
    ard(srp_pkg::P_STAT);
    chk("peer rx", 8'h81, prd[7:0]);
    crd(srp_pkg::DATA_ADDR);
    chk("rx byte", 8'h11, rd);
    cwr(srp_pkg::DATA_ADDR, 8'h7E);
    pxfer(8'h22);
    chk("ss held", 1'b0, lnk.ss_n);
    ard(srp_pkg::P_STAT);
    chk("peer rx", 8'h7E, prd[7:0]);
    break_state <= 1'b1;
    break_clear_enable <= 1'b1;
    crd(srp_pkg::DATA_ADDR);
    chk("rx byte", 8'h22, rd);
    break_state <= 1'b0;
    crd(srp_pkg::STAT_ADDR);
    chk("status", 8'h4F, rd);
  endtask
  // Master with fault detect while select stays low; stop defers the fault
  task automatic t_fault;
    cwr(srp_pkg::CTRL_ADDR, 8'h22);
    stop_mode <= 1'b1;
    cwr(srp_pkg::CTRL_ADDR, 8'h00);
    stop_mode <= 1'b0;
    crd(srp_pkg::CTRL_ADDR);
    chk("ctrl", 8'h20, rd);
    crd(srp_pkg::STAT_ADDR);
    chk("status", 8'h5F, rd);
    chk("irq", 1'b1, irq);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    n_mismatch = 0;
    n_checks = 0;
    {cpu_rd, cpu_wr, wait_mode, stop_mode, break_state, break_clear_enable} = 6'h00;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    cpu_addr = 8'h00;
    cpu_wdata = 8'h00;
    awaddr = 4'h0;
    araddr = 4'h0;
    wdata = 32'h0;
    rst_b = 1'b0;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_reset();
    t_xfer0();
    t_overrun();
    t_wait();
    t_break();
    t_phase1();
    t_fault();
    finish_test();
  end
  // Whole run needs well under this many cycles
  initial
  begin
    repeat (30000) @(posedge ref_clk);
    n_mismatch++;
    $display("BAD watchdog expected done seen timeout");
    finish_test();
  end
endmodule

// *** srp_link_if.sv ***
// Four-wire serial link between the port and its peer
`timescale 1ns/1ps
interface srp_link_if;
  logic dev_sclk_o;
  logic dev_sclk_oe;
  logic dev_mosi_o;
  logic dev_mosi_oe;
  logic dev_miso_o;
  logic dev_miso_oe;
  logic peer_sclk_o;
  logic peer_mosi_o;
  logic peer_ss_n_o;
  logic sclk;
  logic mosi;
  logic miso;
  logic ss_n;
  // Wire levels; an undriven data line floats high on its pullup
  assign sclk = dev_sclk_oe ? dev_sclk_o : peer_sclk_o;
  assign mosi = dev_mosi_oe ? dev_mosi_o : peer_mosi_o;
  assign miso = dev_miso_oe ? dev_miso_o : 1'b1;
  assign ss_n = peer_ss_n_o;
  modport dev (
    output dev_sclk_o, dev_sclk_oe, dev_mosi_o, dev_mosi_oe, dev_miso_o, dev_miso_oe,
    input sclk, mosi, miso, ss_n
  );
  modport peer (
    output peer_sclk_o, peer_mosi_o, peer_ss_n_o,
    input miso
  );
endinterface

// *** srp_link_sva.sv ***
// Wire-level checks on the serial link between the port and its peer
`timescale 1ns/1ps
module srp_link_sva (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic dev_sclk_oe,
  input wire logic dev_mosi_oe,
  input wire logic dev_miso_o,
  input wire logic dev_miso_oe,
  input wire logic sclk,
  input wire logic ss_n
);
  logic [7:0] edge_cnt;
  logic sclk_q;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  // Clock edges seen while selected; cleared whenever deselected
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      edge_cnt <= 8'h00;
      sclk_q <= 1'b0;
    end
    else
    begin
      sclk_q <= sclk;
      if (ss_n)
        edge_cnt <= 8'h00;
      else if (sclk != sclk_q)
        edge_cnt <= edge_cnt + 8'h01;
    end
  end
  // Clock and MISO pins released and peer idle as soon as reset lifts
  reset_idle_a: assert property ($rose(rst_b) |-> ss_n && !dev_miso_oe && !dev_sclk_oe)
    else $error("link not idle after reset");
  // Pin sync plus output flop gives three cycles of lag
  miso_hiz_a: assert property (ss_n [*4] |-> !dev_miso_oe)
    else $error("miso driven while deselected");
  role_excl_a: assert property (dev_miso_oe |-> !dev_sclk_oe && !dev_mosi_oe)
    else $error("slave drives a master pin");
  byte_edges_a: assert property ($rose(ss_n) |-> edge_cnt[3:0] == 4'h0 && edge_cnt != 8'h00)
    else $error("select window not whole bytes");
  ss_gap_a: assert property ($rose(ss_n) |-> ss_n [*2])
    else $error("select gap too short");
  ss_setup_a: assert property ($fell(ss_n) |-> $stable(sclk) [*2])
    else $error("clock moved at select fall");
  clk_select_a: assert property ($changed(sclk) |-> !ss_n)
    else $error("clock toggled while deselected");
  // Slave output may only move in answer to clock or select activity
  miso_hold_a: assert property (($stable(sclk) && $stable(ss_n)) [*5] ##0 dev_miso_oe |->
    $stable(dev_miso_o))
    else $error("miso changed without a clock edge");
  cover property ($rose(ss_n));
  cover property (dev_miso_oe && !ss_n);
  cover property (edge_cnt == 8'h20);
endmodule

// *** srp_peer.sv ***
// Peer master end with an AXI4-Lite command port
`timescale 1ns/1ps
module srp_peer #(
  parameter logic [7:0] HALF_CYC = 8'h08
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  srp_link_if.peer link
);
  typedef struct packed {
    srp_pkg::srp_pstate_e st;
    logic [3:0] bitn;
    logic [7:0] div;
    logic [7:0] shift;
    logic [7:0] rxd;
    logic sck;
    logic ssn;
    logic mosi;
    logic clock_phase_select;
    logic cpol;
    logic hold;
    logic aw_got;
    logic w_got;
    logic [3:0] awa;
    logic [7:0] wd;
    logic ws;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } srp_peer_s;

  srp_peer_s s;
  srp_peer_s next_s;
  logic miso_s;

  // A slave answers only after its own and our input syncs, so a
  // shorter half period would capture the previous bit
  if (HALF_CYC < 8'h06)
  begin : g_chk
    $error("srp_peer: HALF_CYC must be at least 6");
  end

  srp_sync #(.W(1)) u_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .d(link.miso),
    .q(miso_s)
  );

  always_comb
  begin
    logic go;
    logic tick;
    go = 1'b0;
    tick = 1'b0;
    next_s = s;
    // Command port: address and data taken in either order
    if (s.bvalid && s_axi_bready)
      next_s.bvalid = 1'b0;
    if (s.awready && s_axi_awvalid)
    begin
      next_s.aw_got = 1'b1;
      next_s.awa = s_axi_awaddr;
    end
    if (s.wready && s_axi_wvalid)
    begin
      next_s.w_got = 1'b1;
      next_s.wd = s_axi_wdata[7:0];
      next_s.ws = s_axi_wstrb[0];
    end
    if (next_s.aw_got && next_s.w_got && !next_s.bvalid)
    begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = srp_pkg::RESP_OKAY;
      case (next_s.awa)
        srp_pkg::P_CTRL:
        begin
          if (next_s.ws)
            {next_s.hold, next_s.cpol, next_s.clock_phase_select} = next_s.wd[2:0];
        end
        srp_pkg::P_TX: go = next_s.ws && (s.st == srp_pkg::P_IDLE);
        default: next_s.bresp = srp_pkg::RESP_SLVERR;
      endcase
    end
    next_s.awready = !next_s.aw_got && !next_s.bvalid;
    next_s.wready = !next_s.w_got && !next_s.bvalid;
    if (s.rvalid && s_axi_rready)
      next_s.rvalid = 1'b0;
    if (s.arready && s_axi_arvalid)
    begin
      next_s.rvalid = 1'b1;
      next_s.rresp = srp_pkg::RESP_OKAY;
      case (s_axi_araddr)
        srp_pkg::P_CTRL: next_s.rdata = {29'h0, s.hold, s.cpol, s.clock_phase_select};
        srp_pkg::P_STAT: next_s.rdata = {23'h0, s.st != srp_pkg::P_IDLE, s.rxd};
        default:
        begin
          next_s.rdata = 32'h0;
          next_s.rresp = srp_pkg::RESP_SLVERR;
        end
      endcase
    end
    next_s.arready = !next_s.rvalid;
    // Byte sequencer on the half-period enable
    tick = (s.div == HALF_CYC - 8'h01);
    next_s.div = tick ? 8'h00 : s.div + 8'h01;
    case (s.st)
      srp_pkg::P_IDLE:
      begin
        next_s.div = 8'h00;
        next_s.sck = next_s.cpol;
        if (!(next_s.clock_phase_select && next_s.hold))
          next_s.ssn = 1'b1;
        if (go)
        begin
          next_s.st = srp_pkg::P_SETUP;
          next_s.shift = next_s.wd;
          next_s.ssn = 1'b0;
        end
      end
      srp_pkg::P_SETUP:
      begin
        if (tick)
        begin
          next_s.st = srp_pkg::P_SHIFT;
          next_s.bitn = 4'h0;
          next_s.mosi = s.shift[7];
        end
      end
      srp_pkg::P_SHIFT:
      begin
        if (tick)
        begin
          next_s.sck = !s.sck;
          if (s.bitn[0] == s.clock_phase_select)
            next_s.shift = {s.shift[6:0], miso_s};
          else
            next_s.mosi = s.shift[7];
          next_s.bitn = s.bitn + 4'h1;
          if (s.bitn == srp_pkg::EDGE_LAST) // RL17
          begin
            next_s.rxd = next_s.shift;
            next_s.st = (s.clock_phase_select && s.hold) ? srp_pkg::P_IDLE : srp_pkg::P_GAP; // RL21
          end
        end
      end
      srp_pkg::P_GAP:
      begin
        if (tick)
        begin
          next_s.ssn = 1'b1; // RL20
          next_s.st = srp_pkg::P_IDLE;
        end
      end
      default: next_s.st = srp_pkg::P_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s <= '0;
      s.ssn <= 1'b1;
      s.mosi <= 1'b1;
    end
    else
      s <= next_s;
  end

  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bresp = s.bresp;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_arready = s.arready;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rvalid = s.rvalid;
  assign link.peer_sclk_o = s.sck;
  assign link.peer_mosi_o = s.mosi;
  assign link.peer_ss_n_o = s.ssn;
endmodule

// *** srp_pkg.sv ***
// Shared constants and types for the serial port block and its peer
package srp_pkg;
  // Device register offsets on the CPU side
  localparam logic [7:0] CTRL_ADDR = 8'h10;
  localparam logic [7:0] STAT_ADDR = 8'h11;
  localparam logic [7:0] DATA_ADDR = 8'h12;
  // control_reg field positions
  localparam int C_RXIE = 7;
  localparam int C_MSTR = 5;
  localparam int C_CPOL = 4;
  localparam int C_CLOCK_PHASE_SELECT = 3;
  localparam int C_WOM = 2;
  localparam int C_EN = 1;
  localparam int C_TXIE = 0;
  // Master and clock phase 1 set after reset
  localparam logic [7:0] CTRL_RST = 8'h28;
  // status_control_reg field positions
  localparam int S_RXF = 7;
  localparam int S_ERROR_IRQ_ENABLE = 6;
  localparam int S_OVR = 5;
  localparam int S_MODE_FAULT_FLAG = 4;
  localparam int S_TXE = 3;
  localparam int S_MODE_FAULT_DETECT_ENABLE = 2;
  localparam int S_BAUD = 0;
  // Half serial clock period in core cycles, per baud select
  localparam logic [3:0][4:0] BAUD_HALF = {5'h10, 5'h08, 5'h04, 5'h01};
  // Last of sixteen clock edges in one byte
  localparam logic [3:0] EDGE_LAST = 4'hF;
  // Peer register byte addresses
  localparam logic [3:0] P_CTRL = 4'h0;
  localparam logic [3:0] P_TX = 4'h4;
  localparam logic [3:0] P_STAT = 4'h8;
  localparam int P_BUSY = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Peer sequencer, Gray coded along the usual path
  typedef enum logic [1:0]
  {
    P_IDLE = 2'h0,
    P_SETUP = 2'h1,
    P_SHIFT = 2'h3,
    P_GAP = 2'h2
  } srp_pstate_e;
endpackage

// *** srp_port.sv ***
// Serial port core: enable, low power, break and pin ownership
// What this block does
// [RL1] System reset restores every bit and flag
// [RL2] Disabled: tx empty set, transfer aborted, cleared
// [RL3] Disabled: pins go back to general I/O
// [RL4] Disable keeps control bits and receive flags
// [RL5] Master mode fault disables the port
// [RL6] Runs in wait; enabled requests wake CPU
// [RL7] Register access ignored during wait
// [RL8] Software sets error enable for overrun wake
// [RL9] Software disables port before wait to save
// [RL10] Stop freezes state; reset exit aborts
// [RL11] Break without clear enable freezes flags
// [RL12] Break with clear enable allows clears
// [RL13] Data write ignored in protected break
// [RL14] MISO driven only as selected slave
// [RL15] Enabled port owns pin directions
// [RL16] Master drives serial clock; slave receives it
// [RL17] One byte per eight serial clocks
// [RL18] Master shifts out and samples together
// [RL19] Phase 0 slave starts at select fall
// [RL20] Phase 0 select toggles between bytes
// [RL21] Phase 1 select may stay low
// [RL22] Wired-or select makes MOSI open drain
// [RL23] Master ignores select unless fault detect
//
// Design decisions made here: the CPU strobe register port and the address map.
`timescale 1ns/1ps
module srp_port (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [7:0] cpu_addr,
  input wire logic cpu_rd,
  input wire logic cpu_wr,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  input wire logic wait_mode,
  input wire logic stop_mode,
  input wire logic break_state,
  input wire logic break_clear_enable,
  output logic irq,
  output logic pins_owned,
  srp_link_if.dev link
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic error_irq_enable;
    logic mode_fault_detect_enable;
    logic [1:0] baud;
    logic rxf;
    logic ovr;
    logic mode_fault_flag;
    logic txe;
    logic ovr_arm;
    logic mode_fault_flag_arm;
    logic [7:0] txbuf;
    logic [7:0] rxbuf;
    logic [7:0] shift;
    logic dout;
    logic busy;
    logic [3:0] bitn;
    logic sck;
    logic [4:0] div;
    logic ssn_q;
    logic sclk_q;
    logic [7:0] rdata;
    logic irq;
    logic owns;
    logic sclk_o;
    logic sclk_oe;
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
  } srp_port_s;

  srp_port_s s;
  srp_port_s next_s;
  logic [3:0] syn;

  // Every pin input crosses in before use
  srp_sync #(.W(4)) u_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .d({link.ss_n, link.sclk, link.miso, link.mosi}),
    .q(syn)
  );

  always_comb
  begin
    logic en;
    logic mstr;
    logic clock_phase_select;
    logic sw;
    logic ssn;
    logic sedge;
    logic din;
    logic tick;
    logic start;
    logic do_edge;
    logic done;
    logic mf;
    logic acc_rd;
    logic acc_wr;
    en = 1'b0;
    mstr = 1'b0;
    clock_phase_select = 1'b0;
    sw = 1'b0;
    ssn = syn[3];
    sedge = 1'b0;
    din = 1'b0;
    tick = 1'b0;
    start = 1'b0;
    do_edge = 1'b0;
    done = 1'b0;
    mf = 1'b0;
    acc_rd = 1'b0;
    acc_wr = 1'b0;
    next_s = s;
    // Stop halts everything with contents kept
    if (!stop_mode) // RL10
    begin
      en = s.ctrl[srp_pkg::C_EN];
      mstr = s.ctrl[srp_pkg::C_MSTR];
      clock_phase_select = s.ctrl[srp_pkg::C_CLOCK_PHASE_SELECT];
      sw = !(break_state && !break_clear_enable); // RL11 RL12
      // Slave ignores clocks while deselected
      sedge = (syn[2] != s.sclk_q) && !ssn; // RL14
      din = mstr ? syn[1] : syn[0];
      // Partial reset; control bits and rx flags untouched
      if (!en) // RL4
      begin
        next_s.txe = 1'b1; // RL2
        next_s.busy = 1'b0; // RL2
        next_s.bitn = 4'h0; // RL2
        next_s.shift = 8'h00; // RL2
        next_s.div = 5'h00;
        next_s.sck = s.ctrl[srp_pkg::C_CPOL];
      end
      else if (mstr && s.mode_fault_detect_enable && !ssn) // RL23
      begin
        mf = 1'b1;
        next_s.ctrl[srp_pkg::C_EN] = 1'b0; // RL5
        next_s.busy = 1'b0;
        next_s.bitn = 4'h0;
      end
      else if (mstr)
      begin
        // Baud divider gives one enable per half clock
        tick = s.busy && (s.div == srp_pkg::BAUD_HALF[s.baud] - 5'h01);
        next_s.div = (s.busy && !tick) ? s.div + 5'h01 : 5'h00;
        start = !s.busy && !s.txe;
        do_edge = tick;
      end
      else if (!clock_phase_select)
      begin
        start = s.ssn_q && !ssn; // RL19
        do_edge = sedge && s.busy;
      end
      else
      begin
        start = sedge && !s.busy; // RL21
        do_edge = sedge;
      end
      // Empty buffer resends the last shift contents
      if (start)
      begin
        next_s.busy = 1'b1;
        next_s.bitn = 4'h0;
        next_s.sck = s.ctrl[srp_pkg::C_CPOL];
        if (!s.txe)
        begin
          next_s.shift = s.txbuf;
          next_s.txe = 1'b1;
        end
        next_s.dout = next_s.shift[7];
      end
      // Capture and launch alternate; phase picks which comes first
      if (do_edge)
      begin
        next_s.sck = !next_s.sck;
        if (next_s.bitn[0] == clock_phase_select)
          next_s.shift = {next_s.shift[6:0], din}; // RL18
        else
          next_s.dout = next_s.shift[7]; // RL18
        if (next_s.bitn == srp_pkg::EDGE_LAST) // RL17
        begin
          next_s.busy = 1'b0;
          next_s.bitn = 4'h0;
          done = 1'b1;
        end
        else
          next_s.bitn = next_s.bitn + 4'h1;
      end
      // CPU access, shut out during wait
      acc_rd = cpu_rd && !wait_mode; // RL7
      acc_wr = cpu_wr && !wait_mode; // RL7
      if (acc_rd)
      begin
        case (cpu_addr)
          srp_pkg::CTRL_ADDR: next_s.rdata = s.ctrl;
          srp_pkg::STAT_ADDR:
          begin
            next_s.rdata = {s.rxf, s.error_irq_enable, s.ovr, s.mode_fault_flag, s.txe, s.mode_fault_detect_enable, s.baud};
            // First clearing step, kept across a protected break
            if (sw) // RL11
            begin
              next_s.ovr_arm = s.ovr;
              next_s.mode_fault_flag_arm = s.mode_fault_flag;
            end
          end
          srp_pkg::DATA_ADDR:
          begin
            next_s.rdata = s.rxbuf;
            if (sw) // RL11 RL12
            begin
              next_s.rxf = 1'b0;
              if (s.ovr_arm)
                next_s.ovr = 1'b0;
              next_s.ovr_arm = 1'b0;
            end
          end
          default: next_s.rdata = 8'h00;
        endcase
      end
      if (acc_wr)
      begin
        case (cpu_addr)
          srp_pkg::CTRL_ADDR:
          begin
            next_s.ctrl = cpu_wdata;
            if (sw && s.mode_fault_flag_arm) // RL12
            begin
              next_s.mode_fault_flag = 1'b0;
              next_s.mode_fault_flag_arm = 1'b0;
            end
          end
          srp_pkg::STAT_ADDR:
          begin
            next_s.error_irq_enable = cpu_wdata[srp_pkg::S_ERROR_IRQ_ENABLE];
            next_s.mode_fault_detect_enable = cpu_wdata[srp_pkg::S_MODE_FAULT_DETECT_ENABLE];
            next_s.baud = cpu_wdata[srp_pkg::S_BAUD +: 2];
          end
          srp_pkg::DATA_ADDR:
          begin
            if (sw) // RL13
            begin
              next_s.txbuf = cpu_wdata;
              next_s.txe = 1'b0;
            end
          end
          default: next_s.txe = next_s.txe;
        endcase
      end
      // Hardware sets land after clears, so no event is lost
      if (done)
      begin
        if (next_s.rxf)
          next_s.ovr = 1'b1;
        else
        begin
          next_s.rxf = 1'b1;
          next_s.rxbuf = next_s.shift;
        end
      end
      if (mf)
        next_s.mode_fault_flag = 1'b1; // RL5
      next_s.ssn_q = ssn;
      next_s.sclk_q = syn[2];
      // Pin drive follows the settled control state
      en = next_s.ctrl[srp_pkg::C_EN];
      mstr = next_s.ctrl[srp_pkg::C_MSTR];
      next_s.owns = en; // RL3 RL15
      next_s.sclk_oe = en && mstr; // RL16
      next_s.sclk_o = next_s.sck;
      if (next_s.ctrl[srp_pkg::C_WOM]) // RL22
      begin
        next_s.mosi_o = 1'b0;
        next_s.mosi_oe = en && mstr && !next_s.dout;
      end
      else
      begin
        next_s.mosi_o = next_s.dout;
        next_s.mosi_oe = en && mstr;
      end
      next_s.miso_o = next_s.dout;
      next_s.miso_oe = en && !mstr && !ssn; // RL14
      // Request stays live through wait so it can wake the CPU
      next_s.irq = (next_s.rxf && next_s.ctrl[srp_pkg::C_RXIE])
        || (next_s.txe && en && next_s.ctrl[srp_pkg::C_TXIE])
        || (next_s.error_irq_enable && (next_s.ovr || next_s.mode_fault_flag)); // RL6
    end
  end

  // Full reset returns every field to its start value
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b) // RL1 RL10
    begin
      s <= '0;
      s.ctrl <= srp_pkg::CTRL_RST;
      s.txe <= 1'b1;
      s.ssn_q <= 1'b1;
      s.sclk_q <= 1'b0;
    end
    else
      s <= next_s;
  end

  assign cpu_rdata = s.rdata;
  assign irq = s.irq;
  assign pins_owned = s.owns;
  assign link.dev_sclk_o = s.sclk_o;
  assign link.dev_sclk_oe = s.sclk_oe;
  assign link.dev_mosi_o = s.mosi_o;
  assign link.dev_mosi_oe = s.mosi_oe;
  assign link.dev_miso_o = s.miso_o;
  assign link.dev_miso_oe = s.miso_oe;
endmodule

// *** srp_sync.sv ***
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module srp_sync #(
  parameter int W = 4
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } srp_sync_s;
  srp_sync_s s;
  srp_sync_s next_s;

  if (W < 1)
  begin : g_chk
    $error("srp_sync: W must be at least 1");
  end

  // First stage feeds only the second
  always_comb
  begin
    next_s.meta = d;
    next_s.stable = s.meta;
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      s <= '0;
    else
      s <= next_s;
  end

  assign q = s.stable;
endmodule
